// ==== catc_defines.vh ====
// register map, field positions, reset values and source codes of the acquisition trigger block
`ifndef CATC_DEFINES_VH
`define CATC_DEFINES_VH

`define CATC_AW 8
`define CATC_OFS_CTRL 8'h00
`define CATC_OFS_CMD 8'h04
`define CATC_OFS_SRC 8'h08
`define CATC_OFS_USER_OUT 8'h0c
`define CATC_OFS_EXP_TIME 8'h10
`define CATC_OFS_FRAME_PERIOD 8'h14
`define CATC_OFS_BURST 8'h18
`define CATC_OFS_DEBOUNCE 8'h1c
`define CATC_OFS_TIMER_DELAY 8'h20
`define CATC_OFS_READOUT 8'h24
`define CATC_OFS_STATUS 8'h28

`define CATC_CTRL_TRIG_MODE 0
`define CATC_CTRL_ACT_RISING 1
`define CATC_CTRL_EXP_WIDTH 2
`define CATC_CTRL_ACQ_LO 3
`define CATC_CTRL_ACQ_HI 4

`define CATC_CMD_START 0
`define CATC_CMD_STOP 1
`define CATC_CMD_SW_TRIG 2

`define CATC_ACQ_CONT 2'h0
`define CATC_ACQ_ONE_SHOT 2'h1
`define CATC_ACQ_BURST 2'h2

`define CATC_SRC_SW 5'h00
`define CATC_SRC_USER 5'h0a
`define CATC_SRC_CC1 5'h0e
`define CATC_SRC_TIMER 5'h18
`define CATC_SRC_LINE 5'h16

`define CATC_RST_EXP_TIME 32'h0000_0190
`define CATC_RST_FRAME_PERIOD 32'h0000_9c40
`define CATC_RST_BURST 16'h0001
`define CATC_RST_DEBOUNCE 16'h0004
`define CATC_RST_TIMER_DELAY 16'h0000
`define CATC_RST_READOUT 16'h0100

`endif

// ==== catc_sync3.v ====
// three-stage input synchroniser whose output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module catc_sync3 (
    // clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    // asynchronous level in, synchronous level out
    input wire async_i,
    output reg sync_o
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            sync_o <= 1'b0;
        end else if (ce_i) begin
            s1 <= async_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                sync_o <= s3;
            end
        end
    end
endmodule
`default_nettype wire

// ==== catc_debounce.v ====
// debounce filter: a level is passed on only after it has stood for the programmed width
`timescale 1ns/1ps
`default_nettype none
module catc_debounce #(
    parameter W = 16
) (
    // clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    // filter
    input wire [W-1:0] width_i,
    input wire level_i,
    output reg level_o
);
    reg [W-1:0] cnt;
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= {W{1'b0}};
            level_o <= 1'b0;
        end else if (ce_i) begin
            // a pulse shorter than the width restarts the count and is dropped
            if (level_i == level_o) begin
                cnt <= {W{1'b0}};
            end else if ((cnt + 1'b1) >= width_i) begin
                level_o <= level_i;
                cnt <= {W{1'b0}};
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== catc_acq_ctrl.v ====
// acquisition start/stop, exposure trigger selection, exposure timing and strobe with an apb register file
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "catc_defines.vh"
module catc_acq_ctrl #(
    parameter DBW = 16
) (
    // clock, reset, enable
    input wire clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`CATC_AW-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // trigger pins
    input wire hardware_trigger_line_i,
    input wire cc1_i,
    // camera side
    output reg strobe_out_o,
    output reg frame_start_o
);
    localparam S_IDLE = 2'h0;
    localparam S_WAIT = 2'h1;
    localparam S_EXP = 2'h2;
    localparam S_READ = 2'h3;

    // configuration
    reg trig_mode;
    reg act_rising;
    reg exp_width;
    reg [1:0] acq_mode;
    reg [4:0] trig_src;
    reg user_output_line_zero;
    reg [31:0] exp_time;
    reg [31:0] frame_period;
    reg [15:0] frames_per_burst;
    reg [DBW-1:0] debounce_width;
    reg [15:0] timer_delay;
    reg [15:0] readout_time;
    // command pulses
    reg cmd_start;
    reg cmd_stop;
    reg cmd_sw;
    // acquisition state
    reg acquiring;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [31:0] cnt;
    reg [31:0] fr_cnt;
    reg [15:0] frames_left;
    reg [15:0] frames_done;
    reg act_q;
    reg src_lvl;
    reg delay_timer_active;
    reg [15:0] tmr_cnt;
    reg tmr_run;
    reg line_q;
    reg edge_armed;

    wire line_s;
    wire hardware_trigger_line;
    wire cc1_s;

    function valid_addr;
        input [`CATC_AW-1:0] a;
        begin
            case (a)
                `CATC_OFS_CTRL, `CATC_OFS_CMD, `CATC_OFS_SRC, `CATC_OFS_USER_OUT,
                `CATC_OFS_EXP_TIME, `CATC_OFS_FRAME_PERIOD, `CATC_OFS_BURST,
                `CATC_OFS_DEBOUNCE, `CATC_OFS_TIMER_DELAY, `CATC_OFS_READOUT,
                `CATC_OFS_STATUS: valid_addr = 1'b1;
                default: valid_addr = 1'b0;
            endcase
        end
    endfunction

    // activation sense shared by the delay timer and the edge detector
    function sensed;
        input rising;
        input lvl;
        begin
            sensed = rising ? lvl : ~lvl;
        end
    endfunction

    // command bits are one-cycle pulses; one decode keeps all three on the same address
    function cmd_hit;
        input wr_en;
        input [`CATC_AW-1:0] a;
        input [31:0] d;
        input integer pos;
        begin
            cmd_hit = wr_en & (a == `CATC_OFS_CMD) & d[pos];
        end
    endfunction

    // input conditioning
    // both pins get the same three-stage treatment
    wire [1:0] pin_raw = {cc1_i, hardware_trigger_line_i};
    wire [1:0] pin_sync;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin_sync
            catc_sync3 u_sync (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .async_i(pin_raw[gi]),
                .sync_o(pin_sync[gi])
            );
        end
    endgenerate
    assign line_s = pin_sync[0];
    assign cc1_s = pin_sync[1];
    catc_debounce #(.W(DBW)) u_deb_line (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .width_i(debounce_width),
        .level_i(line_s),
        .level_o(hardware_trigger_line)
    );

    // apb access: one wait state, so pready and read data come from flops
    wire apb_acc = psel_i & penable_i;
    wire apb_wr = apb_acc & pready_o & pwrite_i & valid_addr(paddr_i);
    wire [31:0] status_word = {frames_done, 11'h000, (state == S_READ), (state == S_EXP),
                               (state == S_WAIT), (state != S_IDLE), acquiring};

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            pready_o <= apb_acc & ~pready_o;
            pslverr_o <= apb_acc & ~pready_o & ~valid_addr(paddr_i);
            prdata_o <= 32'h0000_0000;
            if (apb_acc & ~pready_o & ~pwrite_i) begin
                case (paddr_i)
                    `CATC_OFS_CTRL: prdata_o <= {27'h0000000, acq_mode, exp_width, act_rising, trig_mode};
                    `CATC_OFS_SRC: prdata_o <= {27'h0000000, trig_src};
                    `CATC_OFS_USER_OUT: prdata_o <= {31'h00000000, user_output_line_zero};
                    `CATC_OFS_EXP_TIME: prdata_o <= exp_time;
                    `CATC_OFS_FRAME_PERIOD: prdata_o <= frame_period;
                    `CATC_OFS_BURST: prdata_o <= {16'h0000, frames_per_burst};
                    `CATC_OFS_DEBOUNCE: prdata_o <= {{(32-DBW){1'b0}}, debounce_width};
                    `CATC_OFS_TIMER_DELAY: prdata_o <= {16'h0000, timer_delay};
                    `CATC_OFS_READOUT: prdata_o <= {16'h0000, readout_time};
                    `CATC_OFS_STATUS: prdata_o <= status_word;
                    default: prdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trig_mode <= 1'b0;
            act_rising <= 1'b1;
            exp_width <= 1'b0;
            acq_mode <= `CATC_ACQ_CONT;
            trig_src <= `CATC_SRC_SW;
            user_output_line_zero <= 1'b0;
            exp_time <= `CATC_RST_EXP_TIME;
            frame_period <= `CATC_RST_FRAME_PERIOD;
            frames_per_burst <= `CATC_RST_BURST;
            debounce_width <= `CATC_RST_DEBOUNCE;
            timer_delay <= `CATC_RST_TIMER_DELAY;
            readout_time <= `CATC_RST_READOUT;
            cmd_start <= 1'b0;
            cmd_stop <= 1'b0;
            cmd_sw <= 1'b0;
        end else if (ce_i) begin
            cmd_start <= cmd_hit(apb_wr, paddr_i, pwdata_i, `CATC_CMD_START);
            cmd_stop <= cmd_hit(apb_wr, paddr_i, pwdata_i, `CATC_CMD_STOP);
            cmd_sw <= cmd_hit(apb_wr, paddr_i, pwdata_i, `CATC_CMD_SW_TRIG);
            if (apb_wr) begin
                case (paddr_i)
                    `CATC_OFS_CTRL: begin
                        trig_mode <= pwdata_i[`CATC_CTRL_TRIG_MODE];
                        act_rising <= pwdata_i[`CATC_CTRL_ACT_RISING];
                        exp_width <= pwdata_i[`CATC_CTRL_EXP_WIDTH];
                        acq_mode <= pwdata_i[`CATC_CTRL_ACQ_HI:`CATC_CTRL_ACQ_LO];
                    end
                    `CATC_OFS_SRC: trig_src <= pwdata_i[4:0];
                    `CATC_OFS_USER_OUT: user_output_line_zero <= pwdata_i[0];
                    `CATC_OFS_EXP_TIME: exp_time <= pwdata_i;
                    `CATC_OFS_FRAME_PERIOD: frame_period <= pwdata_i;
                    `CATC_OFS_BURST: frames_per_burst <= pwdata_i[15:0];
                    `CATC_OFS_DEBOUNCE: debounce_width <= pwdata_i[DBW-1:0];
                    `CATC_OFS_TIMER_DELAY: timer_delay <= pwdata_i[15:0];
                    `CATC_OFS_READOUT: readout_time <= pwdata_i[15:0];
                    default: ;
                endcase
            end
        end
    end

    // delay timer fed by the debounced hardware line: rises timer_delay + 2 cycles after the
    // line's active edge, falls one cycle after the line's opposite edge
    wire line_act = sensed(act_rising, hardware_trigger_line);
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            line_q <= 1'b0;
            tmr_run <= 1'b0;
            tmr_cnt <= 16'h0000;
            delay_timer_active <= 1'b0;
        end else if (ce_i) begin
            line_q <= hardware_trigger_line;
            if (~line_act) begin
                tmr_run <= 1'b0;
                delay_timer_active <= 1'b0;
            end else if ((line_q != hardware_trigger_line) & ~tmr_run) begin
                tmr_run <= 1'b1;
                tmr_cnt <= 16'h0000;
            end else if (tmr_run & ~delay_timer_active) begin
                if (tmr_cnt >= timer_delay) begin
                    delay_timer_active <= 1'b1;
                end else begin
                    tmr_cnt <= tmr_cnt + 16'h0001;
                end
            end
        end
    end

    // source selection; the timer already runs in the active sense, so undo the inversion
    always @* begin
        case (trig_src)
            `CATC_SRC_USER: src_lvl = user_output_line_zero;
            `CATC_SRC_CC1: src_lvl = cc1_s;
            `CATC_SRC_TIMER: src_lvl = sensed(act_rising, delay_timer_active);
            `CATC_SRC_LINE: src_lvl = hardware_trigger_line;
            default: src_lvl = 1'b0;
        endcase
    end

    wire act_lvl = sensed(act_rising, src_lvl);
    wire hw_edge = act_lvl & ~act_q & edge_armed;
    wire sw_sel = (trig_src == `CATC_SRC_SW);
    wire fr_due = (fr_cnt + 32'h0000_0001) >= frame_period;
    wire trig_ev = trig_mode ? (sw_sel ? cmd_sw : hw_edge) : fr_due;
    wire width_mode = trig_mode & ~sw_sel & exp_width;
    wire limited = (acq_mode != `CATC_ACQ_CONT);
    wire exhausted = limited & (frames_left == 16'h0000);
    wire accept = (state == S_WAIT) & acquiring & ~exhausted & trig_ev;
    wire exp_done = width_mode ? ~act_lvl : ((cnt + 32'h0000_0001) >= exp_time);
    wire read_done = (cnt + 32'h0000_0001) >= {16'h0000, readout_time};

    always @* begin
        next_state = state;
        case (state)
            S_IDLE: if (acquiring) next_state = S_WAIT;
            S_WAIT: begin
                if (~acquiring) begin
                    next_state = S_IDLE;
                end else if (accept) begin
                    next_state = S_EXP;
                end
            end
            S_EXP: if (exp_done) next_state = S_READ;
            S_READ: if (read_done) next_state = S_WAIT;
            default: next_state = S_IDLE;
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= S_IDLE;
            acquiring <= 1'b0;
            cnt <= 32'h0000_0000;
            fr_cnt <= 32'h0000_0000;
            frames_left <= 16'h0000;
            frames_done <= 16'h0000;
            act_q <= 1'b0;
            edge_armed <= 1'b0;
            strobe_out_o <= 1'b0;
            frame_start_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            act_q <= act_lvl;
            // a write to source or activation may flip the sensed level, and that is no trigger
            edge_armed <= ~(apb_wr & ((paddr_i == `CATC_OFS_CTRL) | (paddr_i == `CATC_OFS_SRC)));
            strobe_out_o <= (next_state == S_EXP);
            frame_start_o <= accept;
            cnt <= (next_state != state) ? 32'h0000_0000 : cnt + 32'h0000_0001;
            // free-run period counter saturates rather than wrapping
            if (accept | ~acquiring) begin
                fr_cnt <= 32'h0000_0000;
            end else if (fr_cnt != 32'hffff_ffff) begin
                fr_cnt <= fr_cnt + 32'h0000_0001;
            end
            if (accept) begin
                frames_left <= frames_left - 16'h0001;
                frames_done <= frames_done + 16'h0001;
            end
            // start wins over a stop in the same cycle; a stop mid-frame only takes
            // effect once the state machine is back in waiting
            if (cmd_start) begin
                acquiring <= 1'b1;
                frames_done <= 16'h0000;
                frames_left <= (acq_mode == `CATC_ACQ_ONE_SHOT) ? 16'h0001 : frames_per_burst;
            end else if (cmd_stop) begin
                acquiring <= 1'b0;
            end else if ((state == S_WAIT) & exhausted) begin
                acquiring <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== catc_acq_ctrl_chk.sv ====
// assertion checker for the acquisition trigger block
`timescale 1ns/1ps
`default_nettype none
`include "catc_defines.vh"
module catc_acq_chk #(
    parameter DBW = 16
) (
    // clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    // apb
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [`CATC_AW-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    // trigger pins and camera side
    input wire hardware_trigger_line_i,
    input wire cc1_i,
    input wire strobe_out_o,
    input wire frame_start_o
);
    // set once a start command has been taken on the bus
    reg started;
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            started <= 1'b0;
        end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `CATC_OFS_CMD && pwdata_i[0]) begin
            started <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    property p_ready_after_access;
        psel_i && ce_i && $rose(penable_i) |=> pready_o;
    endproperty
    a_ready_after_access: assert property (p_ready_after_access) else $error("no ready after access cycle");
    property p_ready_in_access;
        pready_o |-> psel_i && penable_i;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access phase");
    property p_rdata_idle;
        !pready_o |-> prdata_o == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero while idle");
    property p_err_with_ready;
        pslverr_o |-> pready_o;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_no_frame_before_start;
        frame_start_o |-> started;
    endproperty
    a_no_frame_before_start: assert property (p_no_frame_before_start) else $error("frame before start");
    property p_frame_opens_strobe;
        frame_start_o |-> strobe_out_o && !$past(strobe_out_o);
    endproperty
    a_frame_opens_strobe: assert property (p_frame_opens_strobe) else $error("strobe not opened by frame");
    property p_strobe_needs_frame;
        $rose(strobe_out_o) |-> frame_start_o;
    endproperty
    a_strobe_needs_frame: assert property (p_strobe_needs_frame) else $error("strobe without frame");
    property p_single_start;
        frame_start_o |=> !frame_start_o;
    endproperty
    a_single_start: assert property (p_single_start) else $error("frame start repeated");
    property p_gap_after_exposure;
        $fell(strobe_out_o) |-> (!frame_start_o) [*2];
    endproperty
    a_gap_after_exposure: assert property (p_gap_after_exposure) else $error("frame during readout");
endmodule
bind catc_acq_ctrl catc_acq_chk #(.DBW(DBW)) u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cc1_i(cc1_i),
    .hardware_trigger_line_i(hardware_trigger_line_i), .strobe_out_o(strobe_out_o), .frame_start_o(frame_start_o));
`default_nettype wire

// ==== catc_trig_src.sv ====
// trigger source model: frame grabber control line and external hardware line
`timescale 1ns/1ps
`default_nettype none
module catc_trig_src #(
    parameter MIN_GAP = 8
) (
    // clock
    input wire logic clk_i,
    // trigger lines
    output var logic cc1_o,
    output var logic line_o
);
    initial begin
        cc1_o = 1'b0;
        line_o = 1'b0;
    end
    // both lines are always driven, so there is no floating level to model
    task automatic set_idle(input logic lvl);
        @(posedge clk_i);
        cc1_o <= lvl;
        line_o <= lvl;
    endtask
    task automatic pulse(input logic on_line, input logic act, input int width);
        @(posedge clk_i);
        if (on_line) line_o <= act;
        else cc1_o <= act;
        repeat (width) @(posedge clk_i);
        if (on_line) line_o <= !act;
        else cc1_o <= !act;
        // spacing keeps the trigger rate below what the camera can take
        repeat (MIN_GAP) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ==== camera_acquisition_trigger_control_bench.sv ====
// self-checking bench for the acquisition trigger block
`timescale 1ns/1ps
`default_nettype none
`include "catc_defines.vh"
module camera_acquisition_trigger_control_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd;
    logic prdy, perr, err, cc1, line, strobe, fstart, act, pw;
    logic [31:0] seed = 32'hfea1;
    int miscompares = 0;
    int num_checks = 0;
    int fs = 0;
    int hi = 0;
    int last_w = 0;
    int n0, w, m, s, b;
    logic [7:0] ra [9] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
    logic [31:0] rv [9] = '{32'h2, 32'h0, 32'h0, 32'h190, 32'h9c40, 32'h1, 32'h4, 32'h0, 32'h100};
    logic [4:0] srcs [4] = '{`CATC_SRC_USER, `CATC_SRC_CC1, `CATC_SRC_LINE, `CATC_SRC_TIMER};
    always #12.5 clk = ~clk;
    catc_acq_ctrl #(.DBW(16)) dut (.clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
        .hardware_trigger_line_i(line), .cc1_i(cc1), .strobe_out_o(strobe), .frame_start_o(fstart));
    catc_trig_src trig (.clk_i(clk), .cc1_o(cc1), .line_o(line));
    // frame count and width of the last strobe pulse
    always @(posedge clk) begin
        fs <= fs + (fstart === 1'b1);
        hi <= (strobe === 1'b1) ? hi + 1 : 0;
        if (strobe !== 1'b1 && hi != 0) last_w <= hi;
    end
    function automatic int rnd(input int lo, input int hi_v);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return lo + int'(seed % (hi_v - lo + 1));
    endfunction
    function automatic int exp_frames(input int mode, input int burst, input int trg);
        if (mode == 0) return trg;
        if (mode == 1) return 1;
        return (burst < trg) ? burst : trg;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic rng(input string what, input int lo, input int hv, input int got);
        num_checks++;
        if (got < lo || got > hv) begin
            miscompares++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hv, got);
        end
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr_en;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            report_and_stop();
        end else begin
            rd = prd;
            err = perr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_strobe();
        int n;
        n = 0;
        // let an exposure already under way pass, so the next one is caught at its start
        while (strobe === 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        while (strobe !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    initial begin
        idle(16);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset value", rv[i], rd);
        end
        apb(1'b0, 8'h2c, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped read", 32'h0, rd);
        wr(`CATC_OFS_EXP_TIME, 32'h4);
        wr(`CATC_OFS_READOUT, 32'h4);
        wr(`CATC_OFS_DEBOUNCE, 32'h8);
        wr(`CATC_OFS_FRAME_PERIOD, 32'h14);
        wr(`CATC_OFS_TIMER_DELAY, 32'h3);
        // pulse width asked for, yet software triggers stay timed
        wr(`CATC_OFS_CTRL, 32'h7);
        wr(`CATC_OFS_CMD, 32'h4);
        idle(40);
        rng("frames before start", 0, 0, fs);
        n0 = fs;
        wr(`CATC_OFS_CMD, 32'h1);
        wr(`CATC_OFS_CMD, 32'h4);
        wr(`CATC_OFS_CMD, 32'h4);
        idle(40);
        rng("software frames", 1, 1, fs - n0);
        rng("software exposure", 4, 4, last_w);
        for (m = 0; m < 3; m++) begin
            b = rnd(2, 4);
            wr(`CATC_OFS_BURST, b);
            wr(`CATC_OFS_CTRL, 3 | (m << 3));
            n0 = fs;
            wr(`CATC_OFS_CMD, 32'h1);
            repeat (5) begin
                wr(`CATC_OFS_CMD, 32'h4);
                idle(20);
            end
            rng("frames per mode", exp_frames(m, b, 5), exp_frames(m, b, 5), fs - n0);
            apb(1'b0, `CATC_OFS_STATUS, 32'h0);
            chk("acquiring flag", 32'(m == 0), {31'h0, rd[0]});
            wr(`CATC_OFS_CMD, 32'h2);
        end
        n0 = fs;
        wr(`CATC_OFS_CMD, 32'h4);
        idle(30);
        rng("frames after stop", 0, 0, fs - n0);
        for (s = 0; s < 8; s++) begin
            act = s[0];
            pw = rnd(0, 1);
            wr(`CATC_OFS_CMD, 32'h2);
            trig.set_idle(!act);
            wr(`CATC_OFS_USER_OUT, !act);
            wr(`CATC_OFS_CTRL, 1 | (act << 1) | (pw << 2));
            wr(`CATC_OFS_SRC, srcs[s / 2]);
            idle(30);
            n0 = fs;
            w = rnd(12, 24);
            wr(`CATC_OFS_CMD, 32'h1);
            if (srcs[s / 2] == `CATC_SRC_USER) begin
                wr(`CATC_OFS_USER_OUT, act);
                idle(w);
                wr(`CATC_OFS_USER_OUT, !act);
            end else begin
                trig.pulse(srcs[s / 2] != `CATC_SRC_CC1, act, w);
            end
            idle(40);
            rng("source frames", 1, 1, fs - n0);
            if (!pw) rng("timed exposure", 4, 4, last_w);
            else if (srcs[s / 2] == `CATC_SRC_CC1) rng("width exposure", w - 2, w + 2, last_w);
        end
        wr(`CATC_OFS_CMD, 32'h2);
        trig.set_idle(1'b0);
        wr(`CATC_OFS_CTRL, 32'h3);
        wr(`CATC_OFS_SRC, `CATC_SRC_LINE);
        idle(30);
        n0 = fs;
        wr(`CATC_OFS_CMD, 32'h1);
        trig.pulse(1'b1, 1'b1, 3);
        idle(40);
        rng("short line pulse", 0, 0, fs - n0);
        // longer exposure so the stop surely lands inside it
        wr(`CATC_OFS_EXP_TIME, 32'hc);
        wr(`CATC_OFS_CTRL, 32'h2);
        n0 = fs;
        wr(`CATC_OFS_CMD, 32'h1);
        idle(200);
        rng("free run frames", 200 / 20 - 2, 200 / 20 + 1, fs - n0);
        wait_strobe();
        wr(`CATC_OFS_CMD, 32'h2);
        n0 = fs;
        idle(100);
        rng("exposure through stop", 12, 12, last_w);
        rng("frames after free run stop", 0, 0, fs - n0);
        // start taken on the bus, then the clock enable freezes it before it can act
        n0 = fs;
        wr(`CATC_OFS_CMD, 32'h1);
        ce <= 1'b0;
        idle(60);
        rng("frames while frozen", 0, 0, fs - n0);
        ce <= 1'b1;
        idle(60);
        rng("frames after thaw", 1, 3, fs - n0);
        wr(`CATC_OFS_CMD, 32'h2);
        report_and_stop();
    end
endmodule
`default_nettype wire
